// ### hdl/port_cfg_pkg.sv
// How it works
// - code 02h message processed, reply returned
// - store tag and return path per port
// - stored return path addresses reply and alerts
// - max quota below first quota: invalid field
// - user character enable gates send/forward
// - request_bit_a bit steers dual-port node flag
// - mode field: keep, wrap, normal, privileged
// - mode keep: flush pending alerts before reply
// - wrap only via another port, else invalid
// - entering wrap marks port not operational
// - privileged via other port exits wrap, restarts
// - normal request on wrapped port is invalid
// - extended distance: unsupported invalid, else long timeout
// - extended distance clear: short timeout, option off
// - reduced ack bit forces short timeout
// - nonzero threshold raises one alert on match
// - query clear flag zeroes recovery counter
// - speed mask bits steer negotiation
// - latest valid message parameters overwrite earlier ones
// - dual-speed port at low speed alerts after reply
// - slow speed alert type 06h subtype 05h
// - alert tag held until next configuration
package port_cfg_pkg;
  localparam int NPORTS = 2;
  localparam logic [7:0] CODE_CONFIG = 8'h02;
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_INVALID = 8'hFF;
  localparam logic [7:0] ALERT_TYPE_SLOW = 8'h06;
  localparam logic [7:0] ALERT_SUB_SLOW = 8'h05;
  localparam logic [7:0] ALERT_TYPE_ALARM = 8'h1A;
  localparam logic [7:0] ALERT_SUB_ALARM = 8'h00;
  localparam int CTL_UDC = 7;
  localparam int CTL_REFL = 6;
  localparam int CTL_MODE_HI = 5;
  localparam int CTL_MODE_LO = 4;
  localparam int CTL_EXT = 1;
  localparam int CTL_REDUCED_ACK_TIMEOUT_BIT = 0;
  localparam int SPD_LOW = 0;
  localparam int SPD_HIGH = 1;
  localparam int CLK_MHZ = 100;
  localparam int ACK_SHORT_US = 25;
  localparam int ACK_LONG_US = 100;
  localparam logic [15:0] ACK_SHORT_CYC = 16'(ACK_SHORT_US * CLK_MHZ);
  localparam logic [15:0] ACK_LONG_CYC = 16'(ACK_LONG_US * CLK_MHZ);
  localparam logic [1:0] SPEED_LOW_VAL = 2'h1;

  typedef enum logic [1:0] {MODE_KEEP, MODE_WRAP, MODE_NORMAL, MODE_PRIV} mode_t;

  typedef struct packed {
    logic [7:0]  port;
    logic [15:0] tag;
    logic [31:0] returnPath;
    logic [7:0]  quotaA;
    logic [7:0]  quotaB;
    logic [7:0]  ctl;
    logic [15:0] alarmThreshold;
    logic [7:0]  speedMask;
  } cfg_msg_t;

  typedef struct packed {
    logic [15:0] tag;
    logic [31:0] path;
    logic [7:0]  returnCode;
  } reply_t;

  typedef struct packed {
    logic [15:0] tag;
    logic [31:0] path;
    logic [7:0]  alertType;
    logic [7:0]  subtype;
    logic [7:0]  info;
  } alert_t;

  typedef struct packed {
    logic        udcEnable;
    logic        extDistance;
    logic [15:0] ackTimeout;
    logic [7:0]  quotaA;
    logic [7:0]  quotaB;
    mode_t       mode;
    logic        operational;
    logic        beginComm;
    logic        negHigh;
    logic        negLow;
    logic        singleSpeed;
  } port_state_t;
endpackage

// ### hdl/cfg_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_checker (
  input  wire port_cfg_pkg::cfg_msg_t msg,
  input  wire logic                   arrivalPort,
  input  wire port_cfg_pkg::mode_t    curMode,
  input  wire logic                   extSupported,
  output logic                        invalid
);
  import port_cfg_pkg::*;
  // reserved bits in ctl and bytes 8/12 are never inspected
  wire   logic  sameArrival  = (msg.port[0] == arrivalPort);
  wire   mode_t reqMode      = mode_t'(msg.ctl[CTL_MODE_HI:CTL_MODE_LO]);
  wire   logic  quotaBad     = msg.quotaB < msg.quotaA;
  wire   logic  wrapBad      = (reqMode == MODE_WRAP) && sameArrival;
  wire   logic  normalBad    = (reqMode == MODE_NORMAL) && (curMode == MODE_WRAP);
  wire   logic  extBad       = msg.ctl[CTL_EXT] && !extSupported;
  wire   logic  portBad      = msg.port >= 8'(NPORTS);
  assign invalid = quotaBad | wrapBad | normalBad | extBad | portBad;
endmodule
`default_nettype wire

// ### hdl/alarm_counter.sv
`timescale 1ns/1ps
`default_nettype none
module alarm_counter (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        recoveryEvent,
  input  wire logic        clearCount,
  input  wire logic [15:0] threshold,
  output logic             alarm
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  wire  logic  atMax = &count_q;
  always_comb begin
    count_d = count_q;
    if (recoveryEvent && !atMax) begin
      count_d = count_q + 16'h0001;
    end
    if (clearCount) begin
      count_d = 16'h0000;
    end
  end
  // single pulse exactly on reaching the threshold
  assign alarm = recoveryEvent && !clearCount && (threshold != 16'h0000)
                 && (count_d == threshold) && (count_q != threshold);
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end
endmodule
`default_nettype wire

// ### hdl/port_config_message_handler.sv
`timescale 1ns/1ps
`default_nettype none
module port_config_message_handler (
  input  wire logic                     mclk,
  input  wire logic                     reset,
  input  wire logic                     msgValid,
  input  wire logic [7:0]               msgCode,
  input  wire port_cfg_pkg::cfg_msg_t   msgBody,
  input  wire logic                     arrivalPort,
  input  wire logic                     dualPortNode,
  input  wire logic [1:0]               extSupported,
  input  wire logic [1:0]               dualSpeedCapable,
  input  wire logic [1:0]               runningLowSpeed,
  input  wire logic [1:0]               pendingAlert,
  input  wire logic [1:0]               recoveryEvent,
  input  wire logic                     queryClearValid,
  input  wire logic                     queryClearPort,
  input  wire logic                     alertReady,
  input  wire logic                     replyReady,
  output logic                          msgBusy,
  output logic                          replyValid,
  output port_cfg_pkg::reply_t          reply,
  output logic                          flushPending,
  output logic [7:0]                    flushPort,
  output logic                          alertValid,
  output port_cfg_pkg::alert_t          alert,
  output logic [7:0]                    alertPort,
  output logic                          reflectionFlag,
  output port_cfg_pkg::port_state_t     portState0,
  output port_cfg_pkg::port_state_t     portState1
);
  import port_cfg_pkg::*;

  typedef enum logic [2:0] {IDLE, CHECK, FLUSH, REPLY, SLOWCHK, SLOWALERT} fsm_t;

  fsm_t        state_q;
  fsm_t        state_d;
  cfg_msg_t    msg_q;
  logic        arrival_q;
  logic        invalid_q;
  logic [15:0] tag_q      [NPORTS];
  logic [31:0] path_q     [NPORTS];
  port_state_t pst_q      [NPORTS];
  logic [15:0] thr_q      [NPORTS];
  logic [1:0]  alarmPend_q;
  logic        request_bit_a_q;
  logic        replyValid_q;
  reply_t      reply_q;
  logic        alertValid_q;
  alert_t      alert_q;
  logic [7:0]  alertPort_q;
  logic        flush_q;
  logic        msgBusy_q;
  logic [7:0]  flushPort_q;

  wire  logic  invalid;
  wire  logic  [1:0] alarmHit;
  wire  logic  tgt        = msg_q.port[0];
  wire  mode_t reqMode    = mode_t'(msg_q.ctl[CTL_MODE_HI:CTL_MODE_LO]);
  wire  logic  accept     = msgValid && (msgCode == CODE_CONFIG) && (state_q == IDLE);
  wire  logic  applyCfg   = (state_q == CHECK) && !invalid;
  wire  logic  needFlush  = (reqMode == MODE_KEEP) && pendingAlert[tgt];
  wire  logic  slowNeeded = dualSpeedCapable[tgt] && runningLowSpeed[tgt];
  wire  logic  alarmSlot  = (state_q == IDLE) && !alertValid_q && (alarmPend_q != 2'b00);
  wire  logic  alarmSel   = !alarmPend_q[0];
  wire  logic  bothOper   = pst_q[0].operational && pst_q[1].operational;
  // configuration fields decoded once for both ports
  wire  logic  udcReq     = msg_q.ctl[CTL_UDC];
  wire  logic  reflReq    = msg_q.ctl[CTL_REFL];
  wire  logic  extReq     = msg_q.ctl[CTL_EXT];
  wire  logic  rackReq    = msg_q.ctl[CTL_REDUCED_ACK_TIMEOUT_BIT];
  wire  logic  [1:0] spdReq = {msg_q.speedMask[SPD_HIGH], msg_q.speedMask[SPD_LOW]};
  // checker output settles in CHECK itself; later states use the captured copy
  wire  logic  badNow     = (state_q == CHECK) ? invalid : invalid_q;
  wire  logic  [7:0] replyCode = badNow ? RC_INVALID : RC_OK;
  wire  logic  enterReply = (state_q != REPLY) && (state_d == REPLY);
  wire  logic  slowStart  = (state_q == SLOWCHK) && slowNeeded && !alertValid_q;

  cfg_checker checker_u (
    .msg          (msg_q),
    .arrivalPort  (arrival_q),
    .curMode      (pst_q[tgt].mode),
    .extSupported (extSupported[tgt]),
    .invalid      (invalid)
  );

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      wire logic clr = queryClearValid && (queryClearPort == 1'(g));
      alarm_counter alarm_u (
        .mclk          (mclk),
        .reset         (reset),
        .recoveryEvent (recoveryEvent[g]),
        .clearCount    (clr),
        .threshold     (pst_q[g].beginComm ? 16'h0000 : thr_q[g]),
        .alarm         (alarmHit[g])
      );
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      IDLE:      if (accept) state_d = CHECK;
      CHECK:     state_d = (!invalid && needFlush) ? FLUSH : REPLY;
      FLUSH:     if (!pendingAlert[tgt]) state_d = REPLY;
      REPLY:     if (replyValid_q && replyReady) state_d = SLOWCHK;
      // a queued alarm alert drains first so the slow alert cannot overwrite it
      SLOWCHK: begin
        if (!slowNeeded) state_d = IDLE;
        else if (!alertValid_q) state_d = SLOWALERT;
      end
      SLOWALERT: if (alertValid_q && alertReady) state_d = IDLE;
      default:   state_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // busy and flush port are flops so no top output is decoded from state
  always_ff @(posedge mclk) begin
    if (reset) begin
      msgBusy_q   <= 1'b0;
      flushPort_q <= 8'h00;
    end else begin
      msgBusy_q   <= (state_d != IDLE);
      flushPort_q <= {7'h00, accept ? msgBody.port[0] : tgt};
    end
  end

  // the checker reads the held copy; its verdict is kept for a reply after flush
  always_ff @(posedge mclk) begin
    if (reset) begin
      msg_q     <= '0;
      arrival_q <= 1'b0;
      invalid_q <= 1'b0;
    end else begin
      if (accept) begin
        msg_q     <= msgBody;
        arrival_q <= arrivalPort;
      end
      if (state_q == CHECK) begin
        invalid_q <= invalid;
      end
    end
  end

  generate
    for (g = 0; g < NPORTS; g++) begin : g_cfg
      wire logic hit = applyCfg && (tgt == 1'(g));
      always_ff @(posedge mclk) begin
        if (reset) begin
          tag_q[g]  <= 16'h0000;
          path_q[g] <= 32'h0000_0000;
          thr_q[g]  <= 16'h0000;
          pst_q[g]  <= '{mode: MODE_NORMAL, operational: 1'b1,
                         ackTimeout: ACK_SHORT_CYC, default: '0};
        end else if (state_q == CHECK && tgt == 1'(g)) begin
          // invalid messages still refresh tag and path; parameters stay as they were
          tag_q[g]  <= msg_q.tag;
          path_q[g] <= msg_q.returnPath;
          if (hit) begin
            thr_q[g]           <= msg_q.alarmThreshold;
            pst_q[g].quotaA    <= msg_q.quotaA;
            pst_q[g].quotaB    <= msg_q.quotaB;
            pst_q[g].udcEnable <= udcReq;
            pst_q[g].extDistance <= extReq;
            // counts sit at the low end of each time-out window
            if (extReq && !rackReq) begin
              pst_q[g].ackTimeout <= ACK_LONG_CYC;
            end else begin
              pst_q[g].ackTimeout <= ACK_SHORT_CYC;
            end
            pst_q[g].beginComm <= 1'b0;
            unique case (reqMode)
              MODE_KEEP: ;
              MODE_WRAP: begin
                pst_q[g].mode        <= MODE_WRAP;
                pst_q[g].operational <= 1'b0;
              end
              MODE_NORMAL: pst_q[g].mode <= MODE_NORMAL;
              MODE_PRIV: begin
                if (pst_q[g].mode == MODE_WRAP && arrival_q != 1'(g)) begin
                  pst_q[g].beginComm <= 1'b1;
                end
                pst_q[g].mode <= MODE_PRIV;
              end
            endcase
            unique case (spdReq)
              2'b00: ;
              2'b01: begin
                pst_q[g].negHigh     <= 1'b0;
                pst_q[g].negLow      <= 1'b1;
                pst_q[g].singleSpeed <= 1'b1;
              end
              2'b10: begin
                pst_q[g].negHigh     <= 1'b1;
                pst_q[g].negLow      <= 1'b0;
                pst_q[g].singleSpeed <= 1'b1;
              end
              2'b11: begin
                pst_q[g].negHigh     <= 1'b1;
                pst_q[g].negLow      <= 1'b1;
                pst_q[g].singleSpeed <= 1'b0;
              end
            endcase
          end
        end else begin
          pst_q[g].beginComm <= 1'b0;
        end
      end
    end
  endgenerate

  // request_bit_a is node wide; single port or switch nodes leave it alone
  always_ff @(posedge mclk) begin
    if (reset) begin
      request_bit_a_q <= 1'b0;
    end else if (applyCfg && dualPortNode) begin
      if (reflReq) begin
        request_bit_a_q <= 1'b1;
      end else if (bothOper) begin
        request_bit_a_q <= 1'b0;
      end
    end
  end

  // reply carries the stored path; on invalid the message tag is still used
  always_ff @(posedge mclk) begin
    if (reset) begin
      replyValid_q <= 1'b0;
      reply_q      <= '0;
      flush_q      <= 1'b0;
    end else begin
      flush_q <= (state_d == FLUSH);
      if (enterReply) begin
        replyValid_q       <= 1'b1;
        reply_q.tag        <= msg_q.tag;
        reply_q.path       <= msg_q.returnPath;
        reply_q.returnCode <= replyCode;
      end else if (replyValid_q && replyReady) begin
        replyValid_q <= 1'b0;
      end
    end
  end

  // alarm events wait here until the handler is idle and the alert channel is free; set beats clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      alarmPend_q <= 2'b00;
    end else begin
      alarmPend_q <= (alarmPend_q & ~(alarmSlot ? (alarmSel ? 2'b10 : 2'b01) : 2'b00))
                     | alarmHit;
    end
  end

  // slow alert outranks alarms; every alert reuses the stored tag and path
  always_ff @(posedge mclk) begin
    if (reset) begin
      alertValid_q <= 1'b0;
      alert_q      <= '0;
      alertPort_q  <= 8'h00;
    end else if (slowStart) begin
      alertValid_q      <= 1'b1;
      alert_q.tag       <= tag_q[tgt];
      alert_q.path      <= path_q[tgt];
      alert_q.alertType <= ALERT_TYPE_SLOW;
      alert_q.subtype   <= ALERT_SUB_SLOW;
      alert_q.info      <= {6'h00, SPEED_LOW_VAL};
      alertPort_q       <= {7'h00, tgt};
    end else if (alarmSlot) begin
      alertValid_q      <= 1'b1;
      alert_q.tag       <= tag_q[alarmSel];
      alert_q.path      <= path_q[alarmSel];
      alert_q.alertType <= ALERT_TYPE_ALARM;
      alert_q.subtype   <= ALERT_SUB_ALARM;
      alert_q.info      <= 8'h00;
      alertPort_q       <= {7'h00, alarmSel};
    end else if (alertValid_q && alertReady) begin
      alertValid_q <= 1'b0;
    end
  end

  assign msgBusy        = msgBusy_q;
  assign replyValid     = replyValid_q;
  assign reply          = reply_q;
  assign flushPending   = flush_q;
  assign flushPort      = flushPort_q;
  assign alertValid     = alertValid_q;
  assign alert          = alert_q;
  assign alertPort      = alertPort_q;
  assign reflectionFlag = request_bit_a_q;
  assign portState0     = pst_q[0];
  assign portState1     = pst_q[1];
endmodule
`default_nettype wire

// ### verif/port_config_message_handler_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module port_config_message_handler_monitor
  import port_cfg_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      reset,
  input wire logic                      msgValid,
  input wire logic [7:0]                msgCode,
  input wire port_cfg_pkg::cfg_msg_t    msgBody,
  input wire logic                      arrivalPort,
  input wire logic [1:0]                extSupported,
  input wire logic                      replyReady,
  input wire logic                      alertReady,
  input wire logic                      msgBusy,
  input wire logic                      replyValid,
  input wire port_cfg_pkg::reply_t      reply,
  input wire logic                      flushPending,
  input wire logic                      alertValid,
  input wire port_cfg_pkg::alert_t      alert,
  input wire port_cfg_pkg::port_state_t portState0
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // keep-mode messages are left out: their reply waits on pending alerts
  sequence s_take;
    msgValid && msgCode == CODE_CONFIG && !msgBusy && msgBody.ctl[5:4] != 2'b00;
  endsequence
  property p_reply_time; s_take |-> ##3 replyValid; endproperty
  a_reply_time: assert property (p_reply_time) else $error("reply late");
  property p_reply_addr;
    s_take |-> ##3 reply.tag == $past(msgBody.tag, 3) && reply.path == $past(msgBody.returnPath, 3);
  endproperty
  a_reply_addr: assert property (p_reply_addr) else $error("reply tag or path wrong");
  property p_reply_hold; replyValid && !replyReady |=> replyValid && $stable(reply); endproperty
  a_reply_hold: assert property (p_reply_hold) else $error("reply dropped early");
  property p_alert_hold; alertValid && !alertReady |=> alertValid && $stable(alert); endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped early");
  property p_quota;
    s_take ##0 msgBody.quotaB < msgBody.quotaA |-> ##3 reply.returnCode == RC_INVALID;
  endproperty
  a_quota: assert property (p_quota) else $error("quota order accepted");
  property p_wrap_self;
    s_take ##0 (msgBody.ctl[5:4] == 2'b01 && msgBody.port[0] == arrivalPort)
      |-> ##3 reply.returnCode == RC_INVALID;
  endproperty
  a_wrap_self: assert property (p_wrap_self) else $error("self wrap accepted");
  property p_ext;
    s_take ##0 (msgBody.ctl[CTL_EXT] && !extSupported[msgBody.port[0]])
      |-> ##3 reply.returnCode == RC_INVALID;
  endproperty
  a_ext: assert property (p_ext) else $error("unsupported distance accepted");
  property p_wrap_down; portState0.mode == MODE_WRAP |-> !portState0.operational; endproperty
  a_wrap_down: assert property (p_wrap_down) else $error("wrapped port operational");
  property p_flush; flushPending |-> !replyValid; endproperty
  a_flush: assert property (p_flush) else $error("reply before alerts flushed");
endmodule
bind port_config_message_handler port_config_message_handler_monitor i_mon (
  .mclk(mclk), .reset(reset), .msgValid(msgValid), .msgCode(msgCode), .msgBody(msgBody),
  .arrivalPort(arrivalPort), .extSupported(extSupported), .replyReady(replyReady),
  .alertReady(alertReady), .msgBusy(msgBusy), .replyValid(replyValid), .reply(reply),
  .flushPending(flushPending), .alertValid(alertValid), .alert(alert),
  .portState0(portState0)
);
`default_nettype wire

// ### verif/master_model.sv
`timescale 1ns/1ps
`default_nettype none
module master_model
  import port_cfg_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic [3:0]           stall,
  input  wire logic                 replyValid,
  input  wire port_cfg_pkg::reply_t reply,
  input  wire logic                 alertValid,
  input  wire port_cfg_pkg::alert_t alert,
  output logic                      replyReady,
  output logic                      alertReady,
  output port_cfg_pkg::reply_t      lastReply,
  output port_cfg_pkg::alert_t      lastAlert,
  output int                        replies,
  output int                        alerts
);
  logic [3:0] waitQ;
  // ready is a one-cycle pulse after stall cycles, so slow answers get exercised
  always_ff @(posedge mclk) begin
    if (reset) begin
      replyReady <= 1'b0;
      alertReady <= 1'b0;
      waitQ      <= 4'h0;
      replies    <= 0;
      alerts     <= 0;
    end else begin
      replyReady <= replyValid && !replyReady && waitQ >= stall;
      alertReady <= alertValid && !alertReady && !replyValid && waitQ >= stall;
      waitQ      <= (replyValid || alertValid) ? waitQ + 4'h1 : 4'h0;
      if (replyReady) begin
        lastReply <= reply;
        replies   <= replies + 1;
      end
      if (alertReady) begin
        lastAlert <= alert;
        alerts    <= alerts + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/port_config_message_handler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port_config_message_handler_tb_top;
  import port_cfg_pkg::*;
  logic        mclk = 1'b0, reset = 1'b1, msgValid = 1'b0, arrivalPort = 1'b0;
  logic        dualPortNode = 1'b1, queryClearValid = 1'b0, queryClearPort = 1'b0;
  logic [7:0]  msgCode = CODE_CONFIG;
  cfg_msg_t    msgBody = '0;
  logic [1:0]  extSupported = 2'h0, dualSpeedCapable = 2'h0, runningLowSpeed = 2'h0;
  logic [1:0]  pendingAlert = 2'h0, recoveryEvent = 2'h0;
  logic [3:0]  stall = 4'h0;
  logic        replyReady, alertReady, msgBusy, replyValid, flushPending, alertValid, reflectionFlag;
  logic [7:0]  flushPort, alertPort;
  reply_t      reply, lastReply;
  alert_t      alert, lastAlert;
  port_state_t ps0, ps1;
  int          replies, alerts, begins = 0, miscompares = 0, checked = 0, nRep = 0, nAl = 0, i, k;
  logic [15:0] tag = 16'h0;
  logic [7:0]  spdTab [4] = '{8'h01, 8'h02, 8'h00, 8'h03};
  logic [2:0]  expTab [4] = '{3'b011, 3'b101, 3'b101, 3'b110};
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (ps0.beginComm === 1'b1) begins <= begins + 1;
  port_config_message_handler i_dut (.mclk(mclk), .reset(reset), .msgValid(msgValid),
    .msgCode(msgCode), .msgBody(msgBody), .arrivalPort(arrivalPort), .dualPortNode(dualPortNode),
    .extSupported(extSupported), .dualSpeedCapable(dualSpeedCapable),
    .runningLowSpeed(runningLowSpeed), .pendingAlert(pendingAlert), .recoveryEvent(recoveryEvent),
    .queryClearValid(queryClearValid), .queryClearPort(queryClearPort), .alertReady(alertReady),
    .replyReady(replyReady), .msgBusy(msgBusy), .replyValid(replyValid), .reply(reply),
    .flushPending(flushPending), .flushPort(flushPort), .alertValid(alertValid), .alert(alert),
    .alertPort(alertPort), .reflectionFlag(reflectionFlag), .portState0(ps0), .portState1(ps1));
  master_model i_master (.mclk(mclk), .reset(reset), .stall(stall), .replyValid(replyValid),
    .reply(reply), .alertValid(alertValid), .alert(alert), .replyReady(replyReady),
    .alertReady(alertReady), .lastReply(lastReply), .lastAlert(lastAlert), .replies(replies),
    .alerts(alerts));
  task finish_test;
    if (miscompares == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task hang(input logic stuck);
    if (stuck) begin
      miscompares++;
      finish_test;
    end
  endtask
  task send(input logic [7:0] code, port, input logic arr, input logic [7:0] ctl, spd,
            input logic [15:0] thr, input logic [7:0] qa, qb);
    #1;
    for (i = 0; i < 60 && msgBusy !== 1'b0; i++) @(posedge mclk) #1;
    hang(msgBusy !== 1'b0);
    tag = tag + 16'h1;
    @(posedge mclk);
    msgValid <= 1'b1;
    msgCode <= code;
    arrivalPort <= arr;
    msgBody <= '{port, tag, {16'hCAFE, tag}, qa, qb, ctl, thr, spd};
    @(posedge mclk);
    msgValid <= 1'b0;
  endtask
  task getReply(input logic [7:0] rc);
    nRep++;
    for (i = 0; i < 60 && replies < nRep; i++) @(posedge mclk);
    hang(replies < nRep);
    chk(lastReply, {tag, 16'hCAFE, tag, rc});
  endtask
  // quota a stays nonzero by default, as the master always sends it
  task cfg(input logic [7:0] port, input logic arr, input logic [7:0] ctl, rc,
           input logic [7:0] spd = 8'h03, input logic [15:0] thr = 16'h0,
           input logic [7:0] qa = 8'h04, qb = 8'h08);
    send(CODE_CONFIG, port, arr, ctl, spd, thr, qa, qb);
    getReply(rc);
  endtask
  task waitAlert(input logic [7:0] ty, sub, info);
    nAl++;
    for (i = 0; i < 60 && alerts < nAl; i++) @(posedge mclk);
    hang(alerts < nAl);
    chk(lastAlert, {tag, 16'hCAFE, tag, ty, sub, info});
    chk(alertPort, 8'h00);
  endtask
  task pulse(input int n);
    repeat (n) begin
      @(posedge mclk) recoveryEvent <= 2'h1;
      @(posedge mclk) recoveryEvent <= 2'h0;
    end
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    chk({ps0.mode, ps0.ackTimeout}, {MODE_NORMAL, ACK_SHORT_CYC});
    cfg(8'h0, 1'b1, 8'hEC, RC_OK);
    chk({ps0.udcEnable, reflectionFlag, ps0.quotaA, ps0.quotaB}, 18'h30408);
    cfg(8'h0, 1'b1, 8'h20, RC_OK, 8'h03, 16'h0, 8'h07, 8'h07);
    chk({ps0.udcEnable, reflectionFlag, ps0.quotaA, ps0.quotaB}, 18'h00707);
    cfg(8'h0, 1'b1, 8'h20, RC_INVALID, 8'h03, 16'h0, 8'h05, 8'h04);
    chk(ps0.quotaA, 8'h07);
    dualPortNode <= 1'b0;
    cfg(8'h0, 1'b1, 8'h60, RC_OK);
    chk(reflectionFlag, 1'b0);
    dualPortNode <= 1'b1;
    send(8'h03, 8'h0, 1'b1, 8'h20, 8'h03, 16'h0, 8'h04, 8'h08);
    repeat (8) @(posedge mclk);
    chk(replies, nRep);
    for (k = 0; k < 4; k++) begin
      stall <= 4'(k * 2);
      cfg(8'h0, 1'b1, 8'h20, RC_OK, spdTab[k]);
      chk({ps0.negHigh, ps0.negLow, ps0.singleSpeed}, expTab[k]);
    end
    cfg(8'h0, 1'b1, 8'h22, RC_INVALID);
    extSupported <= 2'h1;
    cfg(8'h0, 1'b1, 8'h22, RC_OK);
    chk({ps0.extDistance, ps0.ackTimeout}, {1'b1, ACK_LONG_CYC});
    cfg(8'h0, 1'b1, 8'h23, RC_OK);
    chk(ps0.ackTimeout, ACK_SHORT_CYC);
    cfg(8'h0, 1'b1, 8'h20, RC_OK);
    chk({ps0.extDistance, ps0.ackTimeout}, {1'b0, ACK_SHORT_CYC});
    cfg(8'h0, 1'b0, 8'h10, RC_INVALID);
    chk(ps0.mode, MODE_NORMAL);
    cfg(8'h0, 1'b1, 8'h10, RC_OK);
    chk({ps0.mode, ps0.operational}, {MODE_WRAP, 1'b0});
    cfg(8'h0, 1'b1, 8'h20, RC_INVALID);
    chk(ps0.mode, MODE_WRAP);
    cfg(8'h0, 1'b1, 8'h30, RC_OK);
    chk({ps0.mode, begins}, {MODE_PRIV, 32'h1});
    cfg(8'h1, 1'b0, 8'h10, RC_OK);
    chk(ps1.mode, MODE_WRAP);
    cfg(8'h2, 1'b0, 8'h20, RC_INVALID);
    pendingAlert <= 2'h1;
    send(CODE_CONFIG, 8'h0, 1'b1, 8'h00, 8'h03, 16'h0, 8'h04, 8'h08);
    repeat (6) @(posedge mclk);
    chk({flushPending, replies, flushPort}, {1'b1, nRep, 8'h00});
    pendingAlert <= 2'h0;
    getReply(RC_OK);
    chk(ps0.mode, MODE_PRIV);
    // the slow-speed alert would repeat after every reply while these stay set
    dualSpeedCapable <= 2'h1;
    runningLowSpeed <= 2'h1;
    cfg(8'h0, 1'b1, 8'h20, RC_OK, 8'h03, 16'h0003);
    waitAlert(ALERT_TYPE_SLOW, ALERT_SUB_SLOW, 8'h01);
    pulse(3);
    waitAlert(ALERT_TYPE_ALARM, ALERT_SUB_ALARM, 8'h00);
    pulse(2);
    repeat (6) @(posedge mclk);
    chk(alerts, nAl);
    @(posedge mclk) queryClearValid <= 1'b1;
    @(posedge mclk) queryClearValid <= 1'b0;
    pulse(3);
    waitAlert(ALERT_TYPE_ALARM, ALERT_SUB_ALARM, 8'h00);
    finish_test;
  end
endmodule
`default_nettype wire
